// ==== shared/cts_pkg.sv ====
// Package for the capacitive touch scan controller: offsets, fields, resets, timing
package cts_pkg;
   // Register addresses on the special function register port
   localparam logic [7:0] CTS_A_SCAN_GO = 8'h00ca;
   localparam logic [7:0] CTS_A_DRV_CFG = 8'h00cb;
   localparam logic [7:0] CTS_A_CHAN_CFG = 8'h00cc;
   localparam logic [7:0] CTS_A_CNT_CFG = 8'h00cd;
   localparam logic [7:0] CTS_A_RAW_LO = 8'h00ce;
   localparam logic [7:0] CTS_A_RAW_HI = 8'h00cf;
   localparam logic [7:0] CTS_A_PULL_LO = 8'h00d1;
   localparam logic [7:0] CTS_A_ANA_CFG = 8'h00d2;
   localparam logic [7:0] CTS_A_SEN0 = 8'h00d3;
   localparam logic [7:0] CTS_A_SEN1 = 8'h00d4;
   localparam logic [7:0] CTS_A_SEN2 = 8'h00d5;
   localparam logic [7:0] CTS_A_SEN3 = 8'h00d6;
   localparam logic [7:0] CTS_A_IRQ_EN = 8'h00e6;
   localparam logic [7:0] CTS_A_IRQ_FLAG = 8'h00f1;
   localparam logic [7:0] CTS_A_IRQ_PRIO = 8'h00f6;
   localparam logic [7:0] CTS_A_PWR = 8'h00fe;

   // Reset values
   localparam logic [7:0] CTS_R_DRV_CFG = 8'h0000;
   localparam logic [7:0] CTS_R_CHAN_CFG = 8'h0040;
   localparam logic [7:0] CTS_R_CNT_CFG = 8'h0070;
   localparam logic [7:0] CTS_R_ANA_CFG = 8'h002d;
   localparam logic [7:0] CTS_R_PWR = 8'h000f;

   // Writable masks
   localparam logic [7:0] CTS_M_DRV = 8'h007f;
   localparam logic [7:0] CTS_M_CHAN = 8'h007f;
   localparam logic [7:0] CTS_M_CNT = 8'h007f;
   localparam logic [7:0] CTS_M_ANA = 8'h003f;
   localparam logic [7:0] CTS_M_SEN3 = 8'h003f;
   localparam logic [7:0] CTS_M_IRQ = 8'h00fc;
   localparam logic [7:0] CTS_M_PWR = 8'h0007;

   // Field positions
   localparam int CTS_B_GO = 0;
   localparam int CTS_B_DRV_GATE = 6;
   localparam int CTS_B_PULL_MSB = 6;
   localparam int CTS_B_PARALLEL = 5;
   localparam int CTS_B_TOUCH_IRQ = 5;
   localparam int CTS_B_PWR_DOWN = 1;
   localparam int CTS_B_PRECHG = 1;
   localparam int CTS_B_PREDIS = 0;

   // Drive clock select codes
   localparam logic [5:0] CTS_SEL_PRS_NORM = 6'h3e;
   localparam logic [5:0] CTS_SEL_PRS_FLAT = 6'h3f;

   // Timing, in the 40 MHz system clock domain
   localparam int CTS_CLK_MHZ = 40;
   localparam int CTS_PRECHG_SHORT_US = 20;
   localparam int CTS_PRECHG_LONG_US = 40;
   localparam int CTS_PREDIS_SHORT_US = 2;
   localparam int CTS_PREDIS_LONG_US = 10;
   localparam logic [10:0] CTS_PRECHG_SHORT_CYC = 11'(CTS_PRECHG_SHORT_US * CTS_CLK_MHZ);
   localparam logic [10:0] CTS_PRECHG_LONG_CYC = 11'(CTS_PRECHG_LONG_US * CTS_CLK_MHZ);
   localparam logic [10:0] CTS_PREDIS_SHORT_CYC = 11'(CTS_PREDIS_SHORT_US * CTS_CLK_MHZ);
   localparam logic [10:0] CTS_PREDIS_LONG_CYC = 11'(CTS_PREDIS_LONG_US * CTS_CLK_MHZ);

   // Count clock: 48 MHz source divided by 2, 4, 8, 12, approximated by a
   // phase accumulator on the 40 MHz clock (step out of 40 = MHz)
   localparam logic [5:0] CTS_CNT_STEP_24 = 6'h18;
   localparam logic [5:0] CTS_CNT_STEP_12 = 6'h0c;
   localparam logic [5:0] CTS_CNT_STEP_6 = 6'h06;
   localparam logic [5:0] CTS_CNT_STEP_4 = 6'h04;
   localparam logic [5:0] CTS_CNT_MOD = 6'h28;
   localparam int CTS_CNT_BASE_BITS = 9;

   // Pseudo-random drive half-period range, in 48 MHz ticks (8 to 23)
   localparam logic [7:0] CTS_PRS_MIN = 8'h08;
   localparam logic [7:0] CTS_DIV_OFS = 8'h04;
   localparam logic [15:0] CTS_LFSR_SEED = 16'hace1;

   typedef enum logic [3:0] {
      CTS_IDLE = 4'b0001,
      CTS_PREDIS = 4'b0010,
      CTS_PRECHG = 4'b0100,
      CTS_COUNT = 4'b1000
   } cts_state_t;
endpackage

// ==== verilog/cts_scan_ctrl.sv ====
// Capacitive touch scan controller: registers, scan sequencer, drive clock
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Writing one starts scan; hardware clears afterwards
// - Clearing trigger mid-scan aborts and resets state
// - Drive gate bit one stops drive clock
// - Codes 0-61 divide 48 MHz by 2(n+4)
// - Codes 62/63 give pseudo-random 1-3 MHz drive
// - Pull-up current code nine bits, msb separate
// - Parallel bit joins enabled channels together
// - Five-bit index picks channel 0 to 29
// - Counter length is width code plus nine
// - Count clock 24, 12, 6 or 4 MHz
// - Pre-charge 20 or 40 microseconds
// - Pre-discharge 2 or 10 microseconds
// - Raw count readable, low then high byte
// - Series resistor codes 4 and 5 only; the register takes any code 0-7 unchecked
// - Threshold code picks eight voltage levels
// - Thirty sensor enable bits connect pins
// - Enable bit gates touch interrupt request
// - Flag bit shows touch interrupt pending
// - Priority bit picks high or low priority
// - Power-down bit holds scanner inoperative
module cts_scan_ctrl
   import cts_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Special function register port
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   // Analog front end
   input wire logic afe_compare_i,
   output logic afe_enable_o,
   output logic afe_drive_clk_o,
   output logic afe_precharge_o,
   output logic afe_predischarge_o,
   output logic afe_count_active_o,
   output logic [8:0] afe_pullup_code_o,
   output logic afe_parallel_o,
   output logic [4:0] afe_channel_o,
   output logic [2:0] afe_resistor_code_o,
   output logic [2:0] afe_threshold_code_o,
   output logic [29:0] afe_sensor_pin_en_o,
   // Interrupt to the core
   output logic irq_touch_o,
   output logic irq_touch_high_prio_o
);

   typedef struct packed {
      cts_state_t state;
      logic scan_go;
      logic [7:0] drv_cfg;
      logic [7:0] chan_cfg;
      logic [7:0] cnt_cfg;
      logic [15:0] raw;
      logic [7:0] pull_lo;
      logic [7:0] ana_cfg;
      logic [29:0] sen;
      logic [7:0] irq_en;
      logic [7:0] irq_flag;
      logic [7:0] irq_prio;
      logic [7:0] pwr;
      logic [10:0] phase_cnt;
      logic [15:0] count;
      logic [5:0] cnt_acc;
      logic [7:0] drv_cnt;
      logic [7:0] drv_period;
      logic drv_clk;
      logic [15:0] lfsr;
      logic [7:0] rdata;
   } cts_regs_t;

   cts_regs_t s_r;
   cts_regs_t s_nxt;

   // Half-period of the drive clock in 48 MHz ticks for a select code
   function automatic logic [7:0] drv_half(input logic [5:0] sel, input logic [15:0] rnd);
      logic [7:0] half;
      half = 8'((8'(sel) + CTS_DIV_OFS));
      if (sel == CTS_SEL_PRS_NORM) begin
         // Sum of three small values: bell-shaped around the centre
         half = CTS_PRS_MIN + 8'(rnd[2:0]) + 8'(rnd[6:4]) + 8'(rnd[9]);
      end else if (sel == CTS_SEL_PRS_FLAT) begin
         half = CTS_PRS_MIN + 8'(rnd[3:0]);
      end
      return half;
   endfunction

   function automatic logic [5:0] cnt_step(input logic [1:0] sel);
      logic [5:0] st;
      unique case (sel)
         2'b00: st = CTS_CNT_STEP_24;
         2'b01: st = CTS_CNT_STEP_12;
         2'b10: st = CTS_CNT_STEP_6;
         2'b11: st = CTS_CNT_STEP_4;
      endcase
      return st;
   endfunction

   logic wr_go;
   logic running;
   logic cnt_tick;
   logic [15:0] cnt_max;
   logic [6:0] acc_sum;
   logic [4:0] width_bits;

   always_comb begin
      s_nxt = s_r;
      wr_go = sfr_wr_i && (sfr_addr_i == CTS_A_SCAN_GO);
      running = (s_r.state != CTS_IDLE);
      width_bits = 5'(s_r.cnt_cfg[6:4]) + 5'(CTS_CNT_BASE_BITS);
      cnt_max = 16'((17'h1_0000 >> (5'd16 - width_bits)) - 17'h0_0001);
      acc_sum = 7'(s_r.cnt_acc) + 7'(cnt_step(s_r.cnt_cfg[3:2]));
      cnt_tick = 1'b0;

      // Register writes
      if (sfr_wr_i) begin
         unique case (sfr_addr_i)
            CTS_A_DRV_CFG: s_nxt.drv_cfg = sfr_wdata_i & CTS_M_DRV;
            CTS_A_CHAN_CFG: s_nxt.chan_cfg = sfr_wdata_i & CTS_M_CHAN;
            CTS_A_CNT_CFG: s_nxt.cnt_cfg = sfr_wdata_i & CTS_M_CNT;
            CTS_A_PULL_LO: s_nxt.pull_lo = sfr_wdata_i;
            CTS_A_ANA_CFG: s_nxt.ana_cfg = sfr_wdata_i & CTS_M_ANA;
            CTS_A_SEN0: s_nxt.sen[7:0] = sfr_wdata_i;
            CTS_A_SEN1: s_nxt.sen[15:8] = sfr_wdata_i;
            CTS_A_SEN2: s_nxt.sen[23:16] = sfr_wdata_i;
            CTS_A_SEN3: s_nxt.sen[29:24] = 6'(sfr_wdata_i & CTS_M_SEN3);
            CTS_A_IRQ_EN: s_nxt.irq_en = sfr_wdata_i & CTS_M_IRQ;
            CTS_A_IRQ_FLAG: s_nxt.irq_flag = sfr_wdata_i & CTS_M_IRQ;
            CTS_A_IRQ_PRIO: s_nxt.irq_prio = sfr_wdata_i & CTS_M_IRQ;
            CTS_A_PWR: s_nxt.pwr = sfr_wdata_i & CTS_M_PWR;
            default: ;
         endcase
      end
      if (wr_go) begin
         s_nxt.scan_go = sfr_wdata_i[CTS_B_GO];
      end

      // Scan sequencer
      s_nxt.lfsr = {s_r.lfsr[14:0], s_r.lfsr[15] ^ s_r.lfsr[13] ^ s_r.lfsr[12] ^ s_r.lfsr[10]};
      unique case (s_r.state)
         CTS_IDLE: begin
            if (wr_go && sfr_wdata_i[CTS_B_GO] && !s_r.pwr[CTS_B_PWR_DOWN]) begin
               s_nxt.state = CTS_PREDIS;
               s_nxt.phase_cnt = s_r.cnt_cfg[CTS_B_PREDIS] ? CTS_PREDIS_LONG_CYC
                                                           : CTS_PREDIS_SHORT_CYC;
            end else if (wr_go && sfr_wdata_i[CTS_B_GO]) begin
               s_nxt.scan_go = 1'b0;
            end
         end
         CTS_PREDIS: begin
            s_nxt.phase_cnt = s_r.phase_cnt - 11'h001;
            if (s_r.phase_cnt == 11'h001) begin
               s_nxt.state = CTS_PRECHG;
               s_nxt.phase_cnt = s_r.cnt_cfg[CTS_B_PRECHG] ? CTS_PRECHG_LONG_CYC
                                                           : CTS_PRECHG_SHORT_CYC;
            end
         end
         CTS_PRECHG: begin
            s_nxt.phase_cnt = s_r.phase_cnt - 11'h001;
            if (s_r.phase_cnt == 11'h001) begin
               s_nxt.state = CTS_COUNT;
               s_nxt.count = 16'h0000;
               s_nxt.cnt_acc = 6'h00;
            end
         end
         CTS_COUNT: begin
            // Count-clock ticks while the comparator reports charging
            if (acc_sum >= 7'(CTS_CNT_MOD)) begin
               s_nxt.cnt_acc = 6'(acc_sum - 7'(CTS_CNT_MOD));
               cnt_tick = 1'b1;
            end else begin
               s_nxt.cnt_acc = 6'(acc_sum);
            end
            if (cnt_tick && afe_compare_i) begin
               s_nxt.count = s_r.count + 16'h0001;
            end
            if (cnt_tick && afe_compare_i && (s_r.count == cnt_max)) begin
               // Completion: result latched, flag set and trigger cleared together
               s_nxt.state = CTS_IDLE;
               s_nxt.raw = s_r.count;
               s_nxt.irq_flag[CTS_B_TOUCH_IRQ] = 1'b1;
               s_nxt.scan_go = 1'b0;
            end
         end
      endcase

      // Abort: trigger cleared or power-down raised mid-scan
      if (running && ((wr_go && !sfr_wdata_i[CTS_B_GO]) || s_r.pwr[CTS_B_PWR_DOWN])) begin
         s_nxt.state = CTS_IDLE;
         s_nxt.scan_go = 1'b0;
         s_nxt.phase_cnt = 11'h000;
         s_nxt.count = 16'h0000;
         s_nxt.cnt_acc = 6'h00;
      end

      // Drive clock: 48 MHz ticks approximated at one per system clock
      if (s_r.drv_cfg[CTS_B_DRV_GATE] || !running) begin
         s_nxt.drv_clk = 1'b0;
         s_nxt.drv_cnt = 8'h00;
         s_nxt.drv_period = drv_half(s_r.drv_cfg[5:0], s_r.lfsr);
      end else if (s_r.drv_cnt + 8'h01 >= s_r.drv_period) begin
         s_nxt.drv_clk = ~s_r.drv_clk;
         s_nxt.drv_cnt = 8'h00;
         s_nxt.drv_period = drv_half(s_r.drv_cfg[5:0], s_r.lfsr);
      end else begin
         s_nxt.drv_cnt = s_r.drv_cnt + 8'h01;
      end

      // Read data register
      s_nxt.rdata = 8'h00;
      if (sfr_rd_i) begin
         unique case (sfr_addr_i)
            CTS_A_SCAN_GO: s_nxt.rdata = {7'h00, s_r.scan_go};
            CTS_A_DRV_CFG: s_nxt.rdata = s_r.drv_cfg;
            CTS_A_CHAN_CFG: s_nxt.rdata = s_r.chan_cfg;
            CTS_A_CNT_CFG: s_nxt.rdata = s_r.cnt_cfg;
            CTS_A_RAW_LO: s_nxt.rdata = s_r.raw[7:0];
            CTS_A_RAW_HI: s_nxt.rdata = s_r.raw[15:8];
            CTS_A_PULL_LO: s_nxt.rdata = s_r.pull_lo;
            CTS_A_ANA_CFG: s_nxt.rdata = s_r.ana_cfg;
            CTS_A_SEN0: s_nxt.rdata = s_r.sen[7:0];
            CTS_A_SEN1: s_nxt.rdata = s_r.sen[15:8];
            CTS_A_SEN2: s_nxt.rdata = s_r.sen[23:16];
            CTS_A_SEN3: s_nxt.rdata = {2'b00, s_r.sen[29:24]};
            CTS_A_IRQ_EN: s_nxt.rdata = s_r.irq_en;
            CTS_A_IRQ_FLAG: s_nxt.rdata = s_r.irq_flag;
            CTS_A_IRQ_PRIO: s_nxt.rdata = s_r.irq_prio;
            CTS_A_PWR: s_nxt.rdata = s_r.pwr;
            default: s_nxt.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_r <= '{state: CTS_IDLE, drv_cfg: CTS_R_DRV_CFG, chan_cfg: CTS_R_CHAN_CFG,
                  cnt_cfg: CTS_R_CNT_CFG, ana_cfg: CTS_R_ANA_CFG, pwr: CTS_R_PWR,
                  lfsr: CTS_LFSR_SEED, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sfr_rdata_o = s_r.rdata;
   assign afe_enable_o = !s_r.pwr[CTS_B_PWR_DOWN];
   assign afe_drive_clk_o = s_r.drv_clk;
   assign afe_precharge_o = (s_r.state == CTS_PRECHG);
   assign afe_predischarge_o = (s_r.state == CTS_PREDIS);
   assign afe_count_active_o = (s_r.state == CTS_COUNT);
   assign afe_pullup_code_o = {s_r.chan_cfg[CTS_B_PULL_MSB], s_r.pull_lo};
   assign afe_parallel_o = s_r.chan_cfg[CTS_B_PARALLEL];
   assign afe_channel_o = s_r.chan_cfg[4:0];
   assign afe_resistor_code_o = s_r.ana_cfg[5:3];
   assign afe_threshold_code_o = s_r.ana_cfg[2:0];
   assign afe_sensor_pin_en_o = s_r.sen;
   assign irq_touch_o = s_r.irq_flag[CTS_B_TOUCH_IRQ] & s_r.irq_en[CTS_B_TOUCH_IRQ];
   assign irq_touch_high_prio_o = s_r.irq_prio[CTS_B_TOUCH_IRQ];

endmodule

`default_nettype wire

// ==== verif/cts_afe_model.sv ====
// Comparator model of the analog front end facing the scan controller
`timescale 1ns/100ps
`default_nettype none
module cts_afe_model (
   // Clock and scan phase
   input wire logic clk_i,
   input wire logic count_active_i,
   input wire logic slow_i,
   // Comparator
   output logic compare_o
);
   logic [2:0] cnt_r = 3'h0;
   always_ff @(posedge clk_i) cnt_r <= cnt_r + 3'h1;
   // Slow: below threshold seven cycles in eight; meaningless when not counting
   always_comb compare_o = count_active_i ? (~slow_i | (|cnt_r)) : cnt_r[0];
endmodule
`default_nettype wire

// ==== verif/cts_scan_ctrl_sva.sv ====
// Port assertions for the scan controller
`timescale 1ns/100ps
`default_nettype none
module cts_scan_ctrl_sva
   import cts_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Register port
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic [7:0] sfr_rdata_o,
   // Front end and interrupt
   input wire logic afe_enable_o,
   input wire logic afe_drive_clk_o,
   input wire logic afe_precharge_o,
   input wire logic afe_predischarge_o,
   input wire logic afe_count_active_o,
   input wire logic irq_touch_high_prio_o
);
   logic [2:0] ph_r;
   logic [15:0] len_r;
   wire logic [2:0] ph = {afe_predischarge_o, afe_precharge_o, afe_count_active_o};
   wire logic busy = |ph;
   // Length of the current run of one phase
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ph_r <= 3'h0;
         len_r <= 16'h0000;
      end else begin
         ph_r <= ph;
         len_r <= (ph == ph_r) ? len_r + 16'h0001 : 16'h0001;
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   sequence go_s;
      sfr_wr_i && sfr_addr_i == CTS_A_SCAN_GO && sfr_wdata_i[0] && !busy;
   endsequence
   sequence stop_s;
      sfr_wr_i && sfr_addr_i == CTS_A_SCAN_GO && !sfr_wdata_i[0] && busy;
   endsequence
   sequence gate_s;
      sfr_wr_i && sfr_addr_i == CTS_A_DRV_CFG && sfr_wdata_i[6];
   endsequence
   sequence idle_s;
      !busy ##1 !busy ##1 !busy;
   endsequence
   a_scan_go_start: assert property (go_s and afe_enable_o |=> afe_predischarge_o)
      else $error("scan did not start");
   a_pwr_down_hold: assert property (go_s and !afe_enable_o |=> !busy)
      else $error("scan ran while powered down");
   a_scan_abort_idle: assert property (stop_s |=> !busy)
      else $error("abort did not stop the scan");
   a_predis_len: assert property ($fell(afe_predischarge_o) && afe_precharge_o
      |-> len_r == 16'h0050 || len_r == 16'h0190)
      else $error("pre-discharge length wrong");
   a_prechg_len: assert property ($fell(afe_precharge_o) && afe_count_active_o
      |-> len_r == 16'h0320 || len_r == 16'h0640)
      else $error("pre-charge length wrong");
   a_gate_clk_off: assert property (gate_s |-> ##2 !afe_drive_clk_o [*4])
      else $error("drive clock ran while gated");
   a_idle_clk_low: assert property (idle_s |-> !afe_drive_clk_o)
      else $error("drive clock ran while idle");
   a_pwr_enable_track: assert property (sfr_wr_i && sfr_addr_i == CTS_A_PWR
      |=> afe_enable_o == !$past(sfr_wdata_i[1]))
      else $error("front end enable wrong");
   a_prio_bit_track: assert property (sfr_wr_i && sfr_addr_i == CTS_A_IRQ_PRIO
      |=> irq_touch_high_prio_o == $past(sfr_wdata_i[5]))
      else $error("priority output wrong");
   a_rdata_idle_zero: assert property (!sfr_rd_i |=> sfr_rdata_o == 8'h00)
      else $error("read data without read");
endmodule
bind cts_scan_ctrl cts_scan_ctrl_sva u_cts_scan_ctrl_sva (.*);
`default_nettype wire

// ==== verif/test_capacitive_touch_scan_ctrl.sv ====
// Self-checking bench for the capacitive touch scan controller
`timescale 1ns/100ps
`default_nettype none
module test_capacitive_touch_scan_ctrl
   import cts_pkg::*;
();
   logic clk_sys_i = 1'h0;
   logic resetn_i = 1'h0;
   logic sfr_wr_i = 1'h0;
   logic sfr_rd_i = 1'h0;
   logic [7:0] sfr_addr_i = 8'h00;
   logic [7:0] sfr_wdata_i = 8'h00;
   logic slow = 1'h0;
   logic [7:0] sfr_rdata_o;
   logic afe_compare_i, afe_enable_o, afe_drive_clk_o, afe_precharge_o, afe_predischarge_o;
   logic afe_count_active_o, afe_parallel_o, irq_touch_o, irq_touch_high_prio_o;
   logic [8:0] afe_pullup_code_o;
   logic [4:0] afe_channel_o;
   logic [2:0] afe_resistor_code_o, afe_threshold_code_o;
   logic [29:0] afe_sensor_pin_en_o;
   int miscompares = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [7:0] ra [16] = '{8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hce, 8'hcf, 8'hd1, 8'hd2, 8'hd3,
      8'hd4, 8'hd5, 8'hd6, 8'he6, 8'hf1, 8'hf6, 8'hfe};
   logic [7:0] rv [16] = '{8'h00, 8'h00, 8'h40, 8'h70, 8'h00, 8'h00, 8'h00, 8'h2d, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f};
   logic [7:0] dsel [4] = '{8'h00, 8'h3d, 8'h3e, 8'h3f};
   cts_scan_ctrl u_cts_scan_ctrl (.*);
   cts_afe_model u_cts_afe_model (.clk_i(clk_sys_i), .count_active_i(afe_count_active_o),
      .slow_i(slow), .compare_o(afe_compare_i));
   initial begin
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         miscompares++;
         close_out();
      end
   end
   task automatic close_out();
      $display("Checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_i);
      sfr_wr_i = 1'h1;
      sfr_addr_i = a;
      sfr_wdata_i = d;
      @(negedge clk_sys_i);
      sfr_wr_i = 1'h0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk_sys_i);
      sfr_rd_i = 1'h1;
      sfr_addr_i = a;
      @(negedge clk_sys_i);
      sfr_rd_i = 1'h0;
      chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, sfr_rdata_o});
   endtask
   task automatic half(output int h);
      logic v;
      h = 0;
      v = afe_drive_clk_o;
      while (afe_drive_clk_o === v) @(negedge clk_sys_i);
      v = afe_drive_clk_o;
      while (afe_drive_clk_o === v) begin
         h++;
         @(negedge clk_sys_i);
      end
   endtask
   task automatic reset_vals();
      for (int i = 0; i < 16; i++) rchk(ra[i], rv[i]);
      chk("pullup code", 16'h0100, {7'h00, afe_pullup_code_o});
      chk("res thr", 16'h002d, {10'h000, afe_resistor_code_o, afe_threshold_code_o});
      wr(CTS_A_SCAN_GO, 8'h01);
      chk("scan while down", 16'h0000, {15'h0000, afe_predischarge_o});
      rchk(CTS_A_SCAN_GO, 8'h00);
   endtask
   task automatic cfg();
      wr(CTS_A_CHAN_CFG, 8'h25);
      wr(CTS_A_PULL_LO, 8'ha5);
      wr(CTS_A_ANA_CFG, 8'h22);
      for (int i = 0; i < 4; i++) wr(CTS_A_SEN0 + 8'(i), 8'h11 * 8'(i + 1) | 8'(i / 3 * 255));
      wr(CTS_A_IRQ_PRIO, 8'h20);
      wr(CTS_A_RAW_LO, 8'h5a);
      chk("pullup code", 16'h00a5, {7'h00, afe_pullup_code_o});
      chk("par chan", 16'h0025, {10'h000, afe_parallel_o, afe_channel_o});
      chk("res thr", 16'h0022, {10'h000, afe_resistor_code_o, afe_threshold_code_o});
      chk("pins low", 16'h2211, afe_sensor_pin_en_o[15:0]);
      chk("pins high", 16'h3f33, {2'h0, afe_sensor_pin_en_o[29:16]});
      chk("high prio", 16'h0001, {15'h0000, irq_touch_high_prio_o});
      rchk(CTS_A_SEN3, 8'h3f);
      rchk(CTS_A_RAW_LO, 8'h00);
      rchk(8'hd0, 8'h00);
   endtask
   task automatic scan(input logic [2:0] w, input logic [1:0] ds, input logic pc,
      input logic pd, input logic en, input logic sl);
      int npd = 0;
      int npc = 0;
      int nct = 0;
      int st = (ds == 2'h3) ? 4 : (24 >> ds);
      int ec = ((1 << (w + 9)) - 1) * 40 / st;
      slow = sl;
      wr(CTS_A_CNT_CFG, {1'h0, w, ds, pc, pd});
      wr(CTS_A_IRQ_EN, {2'h0, en, 5'h00});
      wr(CTS_A_SCAN_GO, 8'h01);
      while (afe_predischarge_o | afe_precharge_o | afe_count_active_o) begin
         npd += int'(afe_predischarge_o);
         npc += int'(afe_precharge_o);
         nct += int'(afe_count_active_o);
         @(negedge clk_sys_i);
      end
      chk("irq at end", {15'h0000, en}, {15'h0000, irq_touch_o});
      chk("predis len", pd ? 16'h0190 : 16'h0050, 16'(npd));
      chk("prechg len", pc ? 16'h0640 : 16'h0320, 16'(npc));
      if (!sl) chk("count span", 16'h0001, {15'h0000, nct - ec <= 45 && ec - nct <= 45});
      rchk(CTS_A_RAW_LO, 8'hff);
      rchk(CTS_A_RAW_HI, 8'((1 << (w + 1)) - 1));
      rchk(CTS_A_SCAN_GO, 8'h00);
      rchk(CTS_A_IRQ_FLAG, 8'h20);
      wr(CTS_A_IRQ_FLAG, 8'h00);
      wr(CTS_A_SCAN_GO, 8'h00);
      chk("irq cleared", 16'h0000, {15'h0000, irq_touch_o});
   endtask
   task automatic drive_abort();
      int h;
      int n;
      wr(CTS_A_CNT_CFG, 8'h03);
      for (int c = 0; c < 4; c++) begin
         wr(CTS_A_DRV_CFG, dsel[c]);
         wr(CTS_A_SCAN_GO, 8'h01);
         half(h);
         if (c < 2) chk("half period", c ? 16'h0041 : 16'h0004, 16'(h));
         else chk("prs half", 16'h0001, {15'h0000, h >= 8 && h <= 24});
         if (c == 3) begin
            wr(CTS_A_DRV_CFG, 8'h7f);
            n = 0;
            repeat (40) begin
               @(negedge clk_sys_i);
               n += int'(afe_drive_clk_o !== 1'h0);
            end
            chk("gated clock", 16'h0000, 16'(n));
         end
         wr(CTS_A_SCAN_GO, 8'h00);
         chk("aborted", 16'h0000, {13'h0000, afe_predischarge_o, afe_precharge_o,
            afe_count_active_o});
      end
      rchk(CTS_A_RAW_LO, 8'hff);
      rchk(CTS_A_IRQ_FLAG, 8'h00);
   endtask
   initial begin
      repeat (2) @(negedge clk_sys_i);
      resetn_i = 1'h1;
      reset_vals();
      cfg();
      wr(CTS_A_PWR, 8'h0d);
      chk("front end on", 16'h0001, {15'h0000, afe_enable_o});
      scan(3'h0, 2'h0, 1'h0, 1'h0, 1'h1, 1'h0);
      scan(3'h1, 2'h1, 1'h1, 1'h1, 1'h1, 1'h0);
      scan(3'h0, 2'h2, 1'h0, 1'h1, 1'h0, 1'h0);
      scan(3'h0, 2'h3, 1'h1, 1'h0, 1'h1, 1'h1);
      drive_abort();
      close_out();
   end
endmodule
`default_nettype wire
